/* File: lbs_supervisor.sv */
// Display bias supply sequencer, fault supervisor and AXI4-Lite status port
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "lbs_params.svh"

// Summary of operation
// (RULE1) Over-temperature shuts down every output
// (RULE2) Restart below lower limit with full sequence
// (RULE3) Undervoltage lockout holds device in shutdown
// (RULE4) Gate rail short: reduced current, boost off
// (RULE5) After threshold passed, short ignored until good
// (RULE6) Short at activation keeps boost off
// (RULE7) Logic rail short acts like enable removal
// (RULE8) Logic rail short: buck at quarter frequency
// (RULE9) Short cleared: buck normal, sequence reruns
// (RULE10) Negative rail short: current and frequency limit
// (RULE11) Buck enable follows buck enable input
// (RULE12) Negative enable starts negative rails, delays
// (RULE13) Boost after boost delay, gate rail later
// (RULE14) Delay ends at capacitor threshold comparator
// (RULE15) Power good released when both rails regulate
// (RULE16) Power good latched until rail short
// (RULE17) Boost switches at fixed rate tick
// (RULE18) Isolation gate sinks after boost delay
// (RULE19) Isolation gate pulled up when disabled
// (RULE20) Boost feedback low too long: latched shutdown
// (RULE21) Fault cleared only by enable or undervoltage
// (RULE22) Soft-start current limit tracks until regulation
// (RULE23) Negative enable gates both delay timers
// (RULE24) Two-stage synchroniser on every async input
// (RULE25) Shutdown clears delay timers and power good
module lbs_supervisor import lbs_pkg::*; #(
  parameter int unsigned BOOST_LOW_QUAL_CYC = `LBS_BOOST_LOW_QUAL_CYC
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic ce,
  // Enable pins
  input wire logic buck_enable_in,
  input wire logic negative_rails_enable_in,
  // Comparator results
  input wire logic over_temp_hi,
  input wire logic temp_below_low,
  input wire logic input_uvlo,
  input wire logic pos_gate_short,
  input wire logic pos_gate_good,
  input wire logic logic_rail_short,
  input wire logic neg_gate_short,
  input wire logic boost_good,
  input wire logic boost_fb_low,
  input wire logic boost_delay_done,
  input wire logic gate_rail_delay_done,
  input wire logic ss_at_max,
  // Converter controls
  output logic buck_enable_out,
  output logic buck_quarter_freq,
  output logic neg_gate_enable,
  output logic neg_gate_limit,
  output logic neg_shunt_enable,
  output logic boost_enable,
  output logic boost_pwm_tick,
  output logic boost_ilim_track,
  output logic pos_gate_enable,
  output logic pos_gate_reduced_current,
  output logic delay_discharge,
  output logic isolation_gate_drive,
  output logic isolation_gate_pullup,
  // Open-drain power good
  output logic power_good_out,
  output logic power_good_oe,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // Input synchronisers
  localparam int NSYNC = 14;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  assign raw_in = {buck_enable_in, negative_rails_enable_in, over_temp_hi, temp_below_low,
                   input_uvlo, pos_gate_short, pos_gate_good, logic_rail_short,
                   neg_gate_short, boost_good, boost_fb_low, boost_delay_done,
                   gate_rail_delay_done, ss_at_max};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end else if (ce) begin
          sync1[gi] <= raw_in[gi]; // [RULE24]
          sync2[gi] <= sync1[gi]; // [RULE24]
        end
      end
    end
  endgenerate
  logic buck_en_s, neg_en_s, ot_s, tlow_s, uvlo_s, pos_short_s, pos_good_s;
  logic logic_short_s, neg_short_s, boost_good_s, boost_low_s, bdly_s, gdly_s, ssmax_s;
  assign {buck_en_s, neg_en_s, ot_s, tlow_s, uvlo_s, pos_short_s, pos_good_s,
          logic_short_s, neg_short_s, boost_good_s, boost_low_s, bdly_s, gdly_s,
          ssmax_s} = sync2;

  // ==========================================================
  // Register file
  logic [31:0] ctrl;
  logic force_off;
  assign force_off = ctrl[`LBS_CTRL_FORCE_OFF];

  // ==========================================================
  // Shutdown conditions
  logic thermal_sd;
  logic shutdown;
  logic neg_run;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      thermal_sd <= 1'b0;
    end else if (ce) begin
      if (ot_s) begin
        thermal_sd <= 1'b1; // [RULE1]
      end else if (tlow_s) begin
        thermal_sd <= 1'b0; // [RULE2]
      end
    end
  end
  assign shutdown = thermal_sd | uvlo_s | force_off; // [RULE1] [RULE3]
  assign neg_run = !shutdown && neg_en_s && !logic_short_s; // [RULE7] [RULE9] [RULE23]

  // ==========================================================
  // Sequencer
  lbs_state_t state;
  lbs_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      LBS_OFF: if (neg_run) next_state = LBS_NEG_ON; // [RULE12]
      LBS_NEG_ON: if (bdly_s) next_state = LBS_BOOST_ON; // [RULE13] [RULE14]
      LBS_BOOST_ON: if (gdly_s) next_state = LBS_ALL_ON; // [RULE13] [RULE14]
      default: next_state = state;
    endcase
    if (!neg_run) begin
      next_state = LBS_OFF; // [RULE25]
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= LBS_OFF;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Positive gate rail short tracking
  logic pos_active;
  logic pos_passed;
  logic pos_pg_seen;
  logic boost_block;
  assign pos_active = (state == LBS_ALL_ON);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pos_passed <= 1'b0;
      pos_pg_seen <= 1'b0;
    end else if (ce) begin
      if (!pos_active) begin
        pos_passed <= 1'b0;
        pos_pg_seen <= 1'b0;
      end else begin
        if (!pos_short_s) pos_passed <= 1'b1; // [RULE5]
        if (pos_good_s) pos_pg_seen <= 1'b1; // [RULE5]
      end
    end
  end
  assign boost_block = pos_active && pos_short_s && (!pos_passed || pos_pg_seen); // [RULE4] [RULE6]

  // ==========================================================
  // Boost low-feedback qualification and latched fault
  logic [17:0] low_cnt;
  logic boost_fault;
  logic boost_run;
  assign boost_run = (state == LBS_BOOST_ON || state == LBS_ALL_ON) && !boost_fault;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt <= '0;
    end else if (ce) begin
      if (!boost_run || !boost_low_s) begin
        low_cnt <= '0;
      end else if (low_cnt != 18'(BOOST_LOW_QUAL_CYC)) begin
        low_cnt <= low_cnt + 18'h0_0001; // [RULE20]
      end
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      boost_fault <= 1'b0;
    end else if (ce) begin
      if (boost_run && low_cnt == 18'(BOOST_LOW_QUAL_CYC)) begin
        boost_fault <= 1'b1; // [RULE20]
      end else if (!neg_en_s || uvlo_s) begin
        boost_fault <= 1'b0; // [RULE21]
      end
    end
  end

  // ==========================================================
  // Power good latch
  logic pg_latch;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pg_latch <= 1'b0;
    end else if (ce) begin
      if (!neg_run || pos_short_s || boost_fault) begin
        pg_latch <= 1'b0; // [RULE16] [RULE25]
      end else if (pos_active && boost_good_s && pos_good_s) begin
        pg_latch <= 1'b1; // [RULE15]
      end
    end
  end

  // ==========================================================
  // Boost switching tick
  logic [7:0] tick_cnt;
  logic next_tick;
  assign next_tick = boost_run && !boost_block && (tick_cnt == 8'(`LBS_BOOST_TICK_CYC - 1));
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt <= '0;
    end else if (ce) begin
      if (!boost_run || boost_block || next_tick) begin
        tick_cnt <= '0;
      end else begin
        tick_cnt <= tick_cnt + 8'h01; // [RULE17]
      end
    end
  end

  // ==========================================================
  // Registered converter controls
  logic next_boost_en;
  logic next_sink;
  assign next_boost_en = boost_run && !boost_block; // [RULE4] [RULE13] [RULE20]
  assign next_sink = boost_run; // [RULE18]
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      buck_enable_out <= 1'b0;
      buck_quarter_freq <= 1'b0;
      neg_gate_enable <= 1'b0;
      neg_gate_limit <= 1'b0;
      neg_shunt_enable <= 1'b0;
      boost_enable <= 1'b0;
      boost_pwm_tick <= 1'b0;
      boost_ilim_track <= 1'b0;
      pos_gate_enable <= 1'b0;
      pos_gate_reduced_current <= 1'b0;
      delay_discharge <= 1'b1;
      isolation_gate_drive <= 1'b0;
      isolation_gate_pullup <= 1'b1;
    end else if (ce) begin
      buck_enable_out <= buck_en_s && !thermal_sd && !uvlo_s && !force_off; // [RULE11]
      buck_quarter_freq <= logic_short_s; // [RULE8] [RULE9]
      neg_gate_enable <= neg_run; // [RULE12]
      neg_gate_limit <= neg_run && neg_short_s; // [RULE10]
      neg_shunt_enable <= neg_run; // [RULE12]
      boost_enable <= next_boost_en;
      boost_pwm_tick <= next_tick; // [RULE17]
      boost_ilim_track <= next_boost_en && !boost_good_s && !ssmax_s; // [RULE22]
      pos_gate_enable <= pos_active; // [RULE13]
      pos_gate_reduced_current <= pos_active && pos_short_s; // [RULE4] [RULE6]
      delay_discharge <= !neg_run; // [RULE23] [RULE25]
      isolation_gate_drive <= next_sink; // [RULE18]
      isolation_gate_pullup <= !next_sink; // [RULE19]
    end
  end
  assign power_good_out = 1'b0;
  assign power_good_oe = !pg_latch; // [RULE15]

  // ==========================================================
  // AXI4-Lite slave
  function automatic logic [1:0] reg_sel(input logic [3:0] addr);
    if (addr == `LBS_OFF_CTRL) reg_sel = 2'd1;
    else if (addr == `LBS_OFF_STATUS) reg_sel = 2'd2;
    else reg_sel = 2'd0;
  endfunction
  logic aw_held, w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] status;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  always_comb begin
    status = '0;
    status[`LBS_ST_STATE +: 2] = state;
    status[`LBS_ST_PG] = pg_latch;
    status[`LBS_ST_THERMAL] = thermal_sd;
    status[`LBS_ST_BOOST_FAULT] = boost_fault;
    status[`LBS_ST_POS_PASSED] = pos_passed;
    status[`LBS_ST_POS_PG_SEEN] = pos_pg_seen;
    status[`LBS_ST_BOOST_ON] = boost_enable;
    status[`LBS_ST_LOGIC_SHORT] = logic_short_s;
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LBS_RESP_OKAY;
      ctrl <= `LBS_CTRL_RESET;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (reg_sel(aw_addr) == 2'd1) begin
          if (w_strb[0]) ctrl[0] <= w_data[0];
          s_axi_bresp <= `LBS_RESP_OKAY;
        end else if (reg_sel(aw_addr) == 2'd2) begin
          s_axi_bresp <= `LBS_RESP_OKAY;
        end else begin
          s_axi_bresp <= `LBS_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `LBS_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        if (reg_sel(s_axi_araddr) == 2'd1) begin
          s_axi_rdata <= ctrl;
          s_axi_rresp <= `LBS_RESP_OKAY;
        end else if (reg_sel(s_axi_araddr) == 2'd2) begin
          s_axi_rdata <= status;
          s_axi_rresp <= `LBS_RESP_OKAY;
        end else begin
          s_axi_rdata <= '0;
          s_axi_rresp <= `LBS_RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Assertions
  property p_thermal_off;
    @(posedge core_clk) disable iff (!reset_n)
      ce && ot_s ##1 ce |=> !buck_enable_out && !neg_gate_enable && power_good_oe;
  endproperty
  a_thermal_off: assert property (p_thermal_off) else $error("outputs on in overtemp"); // [RULE1]
  property p_thermal_hold;
    @(posedge core_clk) disable iff (!reset_n)
      thermal_sd && !tlow_s |=> thermal_sd;
  endproperty
  a_thermal_hold: assert property (p_thermal_hold) else $error("thermal left early"); // [RULE2]
  property p_uvlo;
    @(posedge core_clk) disable iff (!reset_n)
      ce && uvlo_s |=> state == LBS_OFF;
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("sequencer runs in uvlo"); // [RULE3]
  property p_short_at_start;
    @(posedge core_clk) disable iff (!reset_n)
      ce && pos_active && pos_short_s && !pos_passed |=> !boost_enable;
  endproperty
  a_short_at_start: assert property (p_short_at_start) else $error("boost on shorted"); // [RULE6]
  property p_quarter;
    @(posedge core_clk) disable iff (!reset_n)
      ce && logic_short_s |=> buck_quarter_freq && !neg_gate_enable;
  endproperty
  a_quarter: assert property (p_quarter) else $error("logic short not handled"); // [RULE8]
  property p_order;
    @(posedge core_clk) disable iff (!reset_n)
      $rose(pos_gate_enable) |-> $past(boost_enable) || $past(boost_block) || $past(boost_fault);
  endproperty
  a_order: assert property (p_order) else $error("gate rail before boost"); // [RULE13]
  property p_pg_rise;
    @(posedge core_clk) disable iff (!reset_n)
      $fell(power_good_oe) |-> $past(boost_good_s) && $past(pos_good_s);
  endproperty
  a_pg_rise: assert property (p_pg_rise) else $error("pg released early"); // [RULE15]
  property p_low_trip;
    @(posedge core_clk) disable iff (!reset_n)
      ce && boost_run && low_cnt == 18'(BOOST_LOW_QUAL_CYC) ##1 ce
        |=> isolation_gate_pullup && !boost_enable;
  endproperty
  a_low_trip: assert property (p_low_trip) else $error("boost low not latched"); // [RULE20]
  property p_fault_latch;
    @(posedge core_clk) disable iff (!reset_n)
      boost_fault && neg_en_s && !uvlo_s |=> boost_fault;
  endproperty
  a_fault_latch: assert property (p_fault_latch) else $error("fault self cleared"); // [RULE21]
  c_all_on: cover property (@(posedge core_clk) disable iff (!reset_n) $fell(power_good_oe));
  c_fault: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(boost_fault));
  c_logic: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(buck_quarter_freq));
endmodule

/* File: lbs_params.svh */
// Constants for the display bias sequencer and fault supervisor
`ifndef LBS_PARAMS_SVH
`define LBS_PARAMS_SVH
`define LBS_CLK_MHZ 100
`define LBS_BOOST_LOW_QUAL_US 1400
`define LBS_BOOST_LOW_QUAL_CYC (`LBS_BOOST_LOW_QUAL_US * `LBS_CLK_MHZ)
`define LBS_BOOST_FSW_KHZ 750
`define LBS_BOOST_TICK_CYC ((`LBS_CLK_MHZ * 1000) / `LBS_BOOST_FSW_KHZ)
`define LBS_OFF_CTRL 4'h0
`define LBS_OFF_STATUS 4'h4
`define LBS_CTRL_FORCE_OFF 0
`define LBS_CTRL_RESET 32'h0000_0000
`define LBS_ST_STATE 0
`define LBS_ST_PG 2
`define LBS_ST_THERMAL 3
`define LBS_ST_BOOST_FAULT 4
`define LBS_ST_POS_PASSED 5
`define LBS_ST_POS_PG_SEEN 6
`define LBS_ST_BOOST_ON 7
`define LBS_ST_LOGIC_SHORT 8
`define LBS_RESP_OKAY 2'b00
`define LBS_RESP_SLVERR 2'b10
`endif

/* File: lbs_pkg.sv */
// Types for the display bias sequencer and fault supervisor
package lbs_pkg;
  typedef enum logic [1:0] {
    LBS_OFF = 2'b00,
    LBS_NEG_ON = 2'b01,
    LBS_BOOST_ON = 2'b10,
    LBS_ALL_ON = 2'b11
  } lbs_state_t;
endpackage

/* File: lbs_analog_model.sv */
// Behavioural converter stages, comparators and delay capacitors
`timescale 1ns/1ps
module lbs_analog_model (
  // Clock
  input wire logic core_clk,
  // Knobs from the bench
  input wire logic [3:0] boost_delay_timer,
  input wire logic [3:0] gate_rail_delay_timer,
  input wire logic boost_dead,
  input wire logic pos_sc,
  // Controls from the supervisor
  input wire logic delay_discharge,
  input wire logic boost_enable,
  input wire logic pos_gate_enable,
  // Comparator results
  output logic boost_delay_done,
  output logic gate_rail_delay_done,
  output logic boost_good,
  output logic boost_fb_low,
  output logic ss_at_max,
  output logic pos_gate_short,
  output logic pos_gate_good
);
  int c1 = 0;
  int c2 = 0;
  int gb = 0;
  int gp = 0;
  // ==========================================
  // Capacitor ramps and rail rise
  always @(posedge core_clk) begin
    c1 <= delay_discharge ? 0 : c1 + 1;
    c2 <= delay_discharge ? 0 : c2 + 1;
    gb <= (boost_enable && !boost_dead) ? gb + 1 : 0;
    gp <= pos_gate_enable ? gp + 1 : 0;
  end
  // Zero setting acts as an open delay pin
  assign boost_delay_done = c1 >= boost_delay_timer;
  assign gate_rail_delay_done = c2 >= gate_rail_delay_timer;
  assign boost_good = gb >= 8;
  assign boost_fb_low = gb < 2;
  assign ss_at_max = gb >= 4;
  assign pos_gate_short = pos_sc;
  assign pos_gate_good = gp >= 6 && !pos_sc;
endmodule

/* File: lbs_supervisor_tb_top.sv */
// Self-checking bench for the display bias supervisor
`timescale 1ns/1ps
`include "lbs_params.svh"
module lbs_supervisor_tb_top;
  logic core_clk = 0;
  logic reset_n = 0;
  logic ce = 1;
  logic buck_enable_in = 0;
  logic negative_rails_enable_in = 0;
  logic over_temp_hi = 0;
  logic temp_below_low = 1;
  logic input_uvlo = 0;
  logic logic_rail_short = 0;
  logic neg_gate_short = 0;
  logic [3:0] boost_delay_timer = 0;
  logic [3:0] gate_rail_delay_timer = 0;
  logic boost_dead = 0;
  logic pos_sc = 0;
  logic pos_gate_short, pos_gate_good, boost_good, boost_fb_low;
  logic boost_delay_done, gate_rail_delay_done, ss_at_max;
  logic buck_enable_out, buck_quarter_freq, neg_gate_enable, neg_gate_limit;
  logic neg_shunt_enable, boost_enable, boost_pwm_tick, boost_ilim_track;
  logic pos_gate_enable, pos_gate_reduced_current, delay_discharge;
  logic isolation_gate_drive, isolation_gate_pullup, power_good_out, power_good_oe;
  logic [3:0] s_axi_awaddr = 0;
  logic [3:0] s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;
  int t_neg = 0;
  int t_boost = 0;
  int t_pos = 0;
  int n;
  logic ilim_seen = 0;
  integer seed = 32'hf7f2_859d;

  lbs_supervisor #(.BOOST_LOW_QUAL_CYC(20)) u_lbs_supervisor (.*);
  lbs_analog_model u_lbs_analog_model (.*);

  initial begin
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if ($rose(neg_gate_enable)) t_neg <= cyc;
    if ($rose(boost_enable)) t_boost <= cyc;
    if ($rose(pos_gate_enable)) t_pos <= cyc;
    if (boost_ilim_track) ilim_seen <= 1;
  end

  // ==========================================
  // Compare and report
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Expected rail picture from sequencer state
  task automatic rails(logic ng, logic b, logic p, logic g);
    check("neg_gate", neg_gate_enable, ng);
    check("neg_shunt", neg_shunt_enable, ng);
    check("discharge", delay_discharge, !ng);
    check("boost", boost_enable, b);
    check("gate_drive", isolation_gate_drive, b);
    check("gate_pullup", isolation_gate_pullup, !b);
    check("pos_gate", pos_gate_enable, p);
    check("pg_oe", power_good_oe, !g);
  endtask
  task automatic idle(int k);
    repeat (k) @(negedge core_clk);
  endtask
  task automatic started();
    for (n = 0; n < 300 && power_good_oe !== 1'b0; n++) @(negedge core_clk);
    idle(2);
    rails(1, 1, 1, 1);
  endtask

  // ==========================================
  // Register bus master
  task automatic axw(logic [3:0] a, logic [31:0] d, logic [1:0] er);
    logic pa, pw, pb, ka, kw, kb;
    logic [1:0] r;
    pa = 1;
    pw = 1;
    pb = 1;
    r = 2'b11;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 100 && (pa || pw || pb); n++) begin
      @(negedge core_clk);
      ka = pa && s_axi_awready;
      kw = pw && s_axi_wready;
      kb = pb && s_axi_bvalid;
      if (kb) r = s_axi_bresp;
      @(posedge core_clk);
      if (ka) s_axi_awvalid <= 0;
      if (kw) s_axi_wvalid <= 0;
      if (kb) s_axi_bready <= 0;
      pa = pa && !ka;
      pw = pw && !kw;
      pb = pb && !kb;
    end
    check("bresp", r, er);
  endtask
  task automatic axr(logic [3:0] a, logic [31:0] ed, logic [1:0] er);
    logic pa, pr;
    logic [31:0] d;
    logic [1:0] r;
    pa = 1;
    pr = 1;
    d = 'x;
    r = 2'b11;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 100 && pr; n++) begin
      @(negedge core_clk);
      if (pa && s_axi_arready) pa = 0;
      else if (!pa && s_axi_rvalid) pr = 0;
      if (!pr) d = s_axi_rdata;
      if (!pr) r = s_axi_rresp;
      @(posedge core_clk);
      if (!pa) s_axi_arvalid <= 0;
      if (!pr) s_axi_rready <= 0;
    end
    check("rdata", d, ed);
    check("rresp", r, er);
  endtask

  // ==========================================
  // Watchdog
  initial begin
    #600_000;
    mismatches++;
    conclude();
  end

  // ==========================================
  // Scenarios
  initial begin
    idle(6);
    rails(0, 0, 0, 0);
    check("bvalid", s_axi_bvalid, 0);
    @(posedge core_clk) reset_n <= 1;
    @(posedge core_clk) buck_enable_in <= 1;
    idle(6);
    check("buck", buck_enable_out, 1);
    rails(0, 0, 0, 0);
    @(posedge core_clk) boost_delay_timer <= 4'($random(seed));
    @(posedge core_clk) gate_rail_delay_timer <= 4'($random(seed));
    @(posedge core_clk) negative_rails_enable_in <= 1;
    started();
    check("boost_late", t_boost - t_neg >= boost_delay_timer, 1);
    check("pos_late", t_pos - t_neg >= gate_rail_delay_timer, 1);
    check("pos_order", t_pos > t_boost, 1);
    check("ilim", boost_ilim_track, 0);
    check("ilim_seen", ilim_seen, 1);
    check("pg_pin", power_good_out, 0);
    for (n = 0; n < 300 && boost_pwm_tick !== 1'b1; n++) @(negedge core_clk);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (boost_pwm_tick !== 1'b1 && n < 300);
    check("tick", n, `LBS_BOOST_TICK_CYC);
    axr(`LBS_OFF_STATUS, 32'h0000_00e7, `LBS_RESP_OKAY);
    axr(4'h8, 0, `LBS_RESP_SLVERR);
    axw(4'hc, 1, `LBS_RESP_SLVERR);
    axw(`LBS_OFF_STATUS, 0, `LBS_RESP_OKAY);
    axr(`LBS_OFF_STATUS, 32'h0000_00e7, `LBS_RESP_OKAY);
    @(posedge core_clk) neg_gate_short <= 1;
    idle(6);
    check("neg_limit", neg_gate_limit, 1);
    @(posedge core_clk) neg_gate_short <= 0;
    idle(6);
    check("neg_limit", neg_gate_limit, 0);
    @(posedge core_clk) pos_sc <= 1;
    idle(8);
    check("boost", boost_enable, 0);
    check("reduced", pos_gate_reduced_current, 1);
    check("pg_oe", power_good_oe, 1);
    @(posedge core_clk) pos_sc <= 0;
    started();
    @(posedge core_clk) temp_below_low <= 0;
    @(posedge core_clk) over_temp_hi <= 1;
    idle(6);
    @(posedge core_clk) over_temp_hi <= 0;
    idle(10);
    rails(0, 0, 0, 0);
    check("buck", buck_enable_out, 0);
    @(posedge core_clk) pos_sc <= 1;
    @(posedge core_clk) temp_below_low <= 1;
    for (n = 0; n < 300 && pos_gate_enable !== 1'b1; n++) @(negedge core_clk);
    idle(4);
    check("boost", boost_enable, 0);
    check("reduced", pos_gate_reduced_current, 1);
    @(posedge core_clk) pos_sc <= 0;
    started();
    @(posedge core_clk) input_uvlo <= 1;
    idle(10);
    rails(0, 0, 0, 0);
    @(posedge core_clk) input_uvlo <= 0;
    started();
    @(posedge core_clk) logic_rail_short <= 1;
    idle(8);
    rails(0, 0, 0, 0);
    check("buck", buck_enable_out, 1);
    check("quarter", buck_quarter_freq, 1);
    @(posedge core_clk) logic_rail_short <= 0;
    started();
    check("quarter", buck_quarter_freq, 0);
    @(posedge core_clk) boost_dead <= 1;
    idle(40);
    check("boost", boost_enable, 0);
    check("gate_drive", isolation_gate_drive, 0);
    check("gate_pullup", isolation_gate_pullup, 1);
    check("pg_oe", power_good_oe, 1);
    @(posedge core_clk) boost_dead <= 0;
    idle(30);
    check("boost", boost_enable, 0);
    @(posedge core_clk) negative_rails_enable_in <= 0;
    idle(8);
    rails(0, 0, 0, 0);
    @(posedge core_clk) negative_rails_enable_in <= 1;
    started();
    axw(`LBS_OFF_CTRL, 1, `LBS_RESP_OKAY);
    idle(8);
    rails(0, 0, 0, 0);
    axr(`LBS_OFF_CTRL, 1, `LBS_RESP_OKAY);
    axw(`LBS_OFF_CTRL, 0, `LBS_RESP_OKAY);
    started();
    @(posedge core_clk) ce <= 0;
    @(posedge core_clk) negative_rails_enable_in <= 0;
    idle(8);
    check("frozen", neg_gate_enable, 1);
    @(posedge core_clk) ce <= 1;
    idle(8);
    rails(0, 0, 0, 0);
    conclude();
  end
endmodule
